// >>> rtl/swc_consts.svh
// constants for the sleep and wake controller: offsets, fields, reset values, counts
// Functional notes
// [R1] writing one to bit 3 requests sleep
// [R2] sleep halts cpu, oscillator, reference, flash
// [R3] supply monitor and slow oscillator keep running
// [R4] firmware passes through resistive mode first
// [R5] firmware picks pull opposite to driven level
// [R6] three drive registers, bit n is pin n
// [R7] analog high impedance code is 110
// [R8] any reset ends sleep, boot restarts
// [R9] five interrupt sources may wake device
// [R10] pending enabled interrupt blocks sleep bit
// [R11] firmware disables interrupts while preparing sleep
// [R12] wake depends only on mask bits
// [R13] wake with interrupts off leaves it pending
// [R14] firmware clears pending or enables interrupts
// [R15] interrupt wake runs prefetched next instruction
// [R16] interrupts off: execution resumes in sequence
// [R17] no interrupt right after enable instruction
// [R18] sleep timer ticks at 1/8/64/512 Hz
// [R19] sleep starts only after prefetch completes
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
// register byte offsets
`define SWC_OFF_SCR 8'h00
`define SWC_OFF_IMSK 8'h04
`define SWC_OFF_ICLR 8'h08
`define SWC_OFF_TMR 8'h0C
`define SWC_OFF_DM0 8'h10
`define SWC_OFF_DM1 8'h14
`define SWC_OFF_DM2 8'h18
`define SWC_OFF_EVST 8'h1C
`define SWC_OFF_EVMSK 8'h20
// field positions and widths
`define SWC_SCR_SLEEP 3
`define SWC_NSRC 5
`define SWC_NEV 3
`define SWC_EV_SLEPT 0
`define SWC_EV_WOKE 1
`define SWC_EV_REFUSED 2
// reset values
`define SWC_DM0_RST 8'hFF
`define SWC_DM1_RST 8'h00
`define SWC_DM2_RST 8'h00
`define SWC_TMR_RST 2'h0
// slow oscillator rate in hertz and the four timer rates
`define SWC_ILO_HZ 32000
`define SWC_RATE0_HZ 1
`define SWC_RATE1_HZ 8
`define SWC_RATE2_HZ 64
`define SWC_RATE3_HZ 512
`endif

// >>> rtl/swc_pkg.sv
// types for the sleep and wake controller
package swc_pkg;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_ARMED = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE = 4'h8
   } swc_state_e;

   typedef struct packed {
      swc_state_e st;
      logic [1:0] ilo_sync;
      logic ilo_prev;
      logic [1:0] rst_sync;
      logic rst_prev;
      logic [7:0] src_sync1;
      logic [7:0] src_sync2;
      logic [14:0] tmr_cnt;
      logic [1:0] tmr_rate;
      logic [4:0] mask;
      logic [4:0] pend;
      logic [7:0] dm0;
      logic [7:0] dm1;
      logic [7:0] dm2;
      logic [2:0] ev;
      logic [2:0] evmask;
      logic ei_shadow;
      logic boot;
      logic resume;
      logic [31:0] rdata;
      logic slverr;
   } swc_regs_s;
endpackage

// >>> rtl/swc_top.sv
// sleep and wake controller with apb registers and port drive modes
`include "swc_consts.svh"

module swc_top #(
   parameter int ILO_HZ = `SWC_ILO_HZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // asynchronous pins: slow oscillator, reset causes, wake sources
   input wire logic ilo_clk,
   input wire logic ext_rst,
   input wire logic wdt_rst,
   input wire logic por_rst,
   input wire logic lvd_irq,
   input wire logic gpio_irq,
   input wire logic acol_irq,
   input wire logic async_irq,
   // cpu side, same clock
   input wire logic gie,
   input wire logic ei_exec,
   input wire logic instr_boundary,
   input wire logic prefetch_done,
   output logic cpu_halt,
   output logic cpu_int_req,
   output logic boot_restart,
   output logic resume_next,
   // power controls
   output logic imo_en,
   output logic bandgap_en,
   output logic flash_en,
   output logic lvm_en,
   output logic ilo_en,
   // port drive modes
   output logic [7:0] port_dm_low,
   output logic [7:0] port_dm_mid,
   output logic [7:0] port_dm_high,
   output logic [7:0] port_analog_hiz,
   // interrupt
   output logic irq
);

   // timer terminal counts in slow oscillator ticks
   localparam logic [14:0] TC0 = 15'(ILO_HZ / `SWC_RATE0_HZ - 1);
   localparam logic [14:0] TC1 = 15'(ILO_HZ / `SWC_RATE1_HZ - 1);
   localparam logic [14:0] TC2 = 15'(ILO_HZ / `SWC_RATE2_HZ - 1);
   localparam logic [14:0] TC3 = 15'(ILO_HZ / `SWC_RATE3_HZ - 1);

   swc_pkg::swc_regs_s r_q;
   swc_pkg::swc_regs_s r_d;

   logic wr;
   logic rd_setup;
   logic sleep_wr;
   logic wake_req;
   logic int_blocked;
   logic ilo_rise;
   logic tmr_hit;
   logic rst_any;
   logic rst_fell;
   logic [4:0] src_lvl;
   logic [4:0] clr_mask;
   logic [2:0] ev_set;
   logic [14:0] tmr_tc;

   // terminal count for the selected rate
   function automatic logic [14:0] rate_tc(input logic [1:0] sel);
      case (sel)
         2'h0: rate_tc = TC0;
         2'h1: rate_tc = TC1;
         2'h2: rate_tc = TC2;
         default: rate_tc = TC3;
      endcase
   endfunction

   // address decode, shared by write strobe and slave error
   function automatic logic addr_ok(input logic [7:0] a);
      case (a)
         `SWC_OFF_SCR, `SWC_OFF_IMSK, `SWC_OFF_ICLR, `SWC_OFF_TMR, `SWC_OFF_DM0,
         `SWC_OFF_DM1, `SWC_OFF_DM2, `SWC_OFF_EVST, `SWC_OFF_EVMSK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   endfunction

   // decoded strobes and events; zero wait states, so ready is constant
   always_comb
   begin
      wr = psel && penable && pwrite && addr_ok(paddr);
      rd_setup = psel && !penable;
      sleep_wr = wr && paddr == `SWC_OFF_SCR && pwdata[`SWC_SCR_SLEEP]; // [R1]
      src_lvl = {r_q.src_sync2[3:0], 1'b0};
      wake_req = |(r_q.pend & r_q.mask); // mask alone decides wake [R12]
      // an enable instruction hides interrupts in its own cycle and for one clock cycle after it [R17]
      int_blocked = r_q.ei_shadow || ei_exec;
      ilo_rise = r_q.ilo_sync[1] && !r_q.ilo_prev;
      tmr_tc = rate_tc(r_q.tmr_rate);
      tmr_hit = ilo_rise && r_q.tmr_cnt == tmr_tc; // [R18]
      rst_any = r_q.rst_sync[1];
      rst_fell = r_q.rst_prev && !r_q.rst_sync[1]; // falling edge from the second flop and its delayed copy [R8]
      clr_mask = (wr && paddr == `SWC_OFF_ICLR) ? pwdata[4:0] : 5'h00;
      // hardware events, each a one-cycle set into the sticky status
      ev_set = 3'h0;
      ev_set[`SWC_EV_SLEPT] = r_q.st == swc_pkg::ST_ARMED && instr_boundary && prefetch_done && !rst_any;
      ev_set[`SWC_EV_WOKE] = r_q.st == swc_pkg::ST_SLEEP && wake_req && !rst_any;
      ev_set[`SWC_EV_REFUSED] = r_q.st == swc_pkg::ST_RUN && sleep_wr && wake_req && gie; // [R10]
   end

   // next-state logic for the whole block
   always_comb
   begin
      r_d = r_q;
      // two flops on every asynchronous pin before use
      r_d.ilo_sync = {r_q.ilo_sync[0], ilo_clk};
      r_d.ilo_prev = r_q.ilo_sync[1];
      r_d.rst_sync = {r_q.rst_sync[0], ext_rst || wdt_rst || por_rst};
      r_d.rst_prev = r_q.rst_sync[1];
      r_d.src_sync1 = {4'h0, async_irq, acol_irq, gpio_irq, lvd_irq};
      r_d.src_sync2 = r_q.src_sync1;
      r_d.boot = 1'b0;
      r_d.resume = 1'b0;
      r_d.ei_shadow = ei_exec;
      // sleep timer keeps counting in every state, it runs off the slow clock [R3]
      if (ilo_rise)
         r_d.tmr_cnt = tmr_hit ? 15'h0000 : 15'(r_q.tmr_cnt + 15'h0001);
      // pending requests: set wins over a clear in the same cycle [R9]
      r_d.pend = (r_q.pend & ~clr_mask) | src_lvl | {4'h0, tmr_hit};
      // register writes
      if (wr)
      begin
         case (paddr)
            `SWC_OFF_IMSK: r_d.mask = pwdata[4:0];
            `SWC_OFF_TMR:
            begin
               r_d.tmr_rate = pwdata[1:0];
               r_d.tmr_cnt = 15'h0000;
            end
            `SWC_OFF_DM0: r_d.dm0 = pwdata[7:0]; // [R6]
            `SWC_OFF_DM1: r_d.dm1 = pwdata[7:0]; // [R6]
            `SWC_OFF_DM2: r_d.dm2 = pwdata[7:0]; // [R6]
            `SWC_OFF_EVMSK: r_d.evmask = pwdata[2:0];
            default: r_d.evmask = r_q.evmask;
         endcase
      end
      // sleep sequencer
      case (r_q.st)
         swc_pkg::ST_RUN:
         begin
            if (sleep_wr)
            begin
               // an enabled pending interrupt wins: the bit stays clear [R10]
               if (!(wake_req && gie))
                  r_d.st = swc_pkg::ST_ARMED; // [R1]
            end
         end
         swc_pkg::ST_ARMED:
         begin
            // wait for the next instruction to be fully fetched [R19]
            if (instr_boundary && prefetch_done)
            begin
               r_d.st = swc_pkg::ST_SLEEP;
            end
         end
         swc_pkg::ST_SLEEP:
         begin
            // masked-in request wakes whatever the global flag says [R12]
            if (wake_req)
            begin
               r_d.st = swc_pkg::ST_WAKE;
               r_d.resume = 1'b1; // [R15]
            end
         end
         swc_pkg::ST_WAKE:
            r_d.st = swc_pkg::ST_RUN; // resume in sequence [R16]
         default: r_d.st = swc_pkg::ST_RUN;
      endcase
      // event status: write one to clear, hardware set wins
      if (wr && paddr == `SWC_OFF_EVST)
         r_d.ev = r_q.ev & ~pwdata[2:0];
      r_d.ev = r_d.ev | ev_set; // a set in the clearing cycle survives
      // any reset cause ends sleep and restarts at boot [R8]
      if (rst_any)
      begin
         r_d.st = swc_pkg::ST_RUN;
         r_d.resume = 1'b0;
      end
      r_d.boot = rst_fell; // [R8]
      // read data captured in setup, presented in the access phase
      if (rd_setup)
      begin
         r_d.slverr = !addr_ok(paddr);
         case (paddr)
            `SWC_OFF_SCR: r_d.rdata = {28'h0, (r_q.st != swc_pkg::ST_RUN), 3'h0};
            `SWC_OFF_IMSK: r_d.rdata = {27'h0, r_q.mask};
            `SWC_OFF_ICLR: r_d.rdata = {27'h0, r_q.pend};
            `SWC_OFF_TMR: r_d.rdata = {30'h0, r_q.tmr_rate};
            `SWC_OFF_DM0: r_d.rdata = {24'h0, r_q.dm0};
            `SWC_OFF_DM1: r_d.rdata = {24'h0, r_q.dm1};
            `SWC_OFF_DM2: r_d.rdata = {24'h0, r_q.dm2};
            `SWC_OFF_EVST: r_d.rdata = {29'h0, r_q.ev};
            `SWC_OFF_EVMSK: r_d.rdata = {29'h0, r_q.evmask};
            default: r_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // single state register, synchronous reset
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r_q <= '0;
         r_q.st <= swc_pkg::ST_RUN;
         r_q.dm0 <= `SWC_DM0_RST;
         r_q.dm1 <= `SWC_DM1_RST;
         r_q.dm2 <= `SWC_DM2_RST;
         r_q.tmr_rate <= `SWC_TMR_RST;
      end
      else
         r_q <= r_d;
   end

   // outputs; imo, bandgap and flash enables follow the state flop directly, supply monitor and slow oscillator stay on
   assign pready = 1'b1;
   assign prdata = r_q.rdata;
   assign pslverr = r_q.slverr;
   assign cpu_halt = r_q.st == swc_pkg::ST_SLEEP; // [R2]
   assign imo_en = r_q.st != swc_pkg::ST_SLEEP; // [R2]
   assign bandgap_en = r_q.st != swc_pkg::ST_SLEEP; // [R2]
   assign flash_en = r_q.st != swc_pkg::ST_SLEEP; // [R2]
   assign lvm_en = 1'b1; // [R3]
   assign ilo_en = 1'b1; // [R3]
   // service only when awake, globally enabled and not shadowed [R13] [R17]
   assign cpu_int_req = wake_req && gie && !int_blocked && r_q.st == swc_pkg::ST_RUN;
   assign boot_restart = r_q.boot;
   assign resume_next = r_q.resume; // [R15]
   assign port_dm_low = r_q.dm0;
   assign port_dm_mid = r_q.dm1;
   assign port_dm_high = r_q.dm2;
   assign port_analog_hiz = r_q.dm2 & r_q.dm1 & ~r_q.dm0; // [R7]
   assign irq = |(r_q.ev & r_q.evmask);

   // assertions
   sequence s_woke;
      r_q.st == swc_pkg::ST_WAKE && resume_next;
   endsequence

   sequence s_back_run;
      r_q.st == swc_pkg::ST_RUN;
   endsequence

   property p_sleep_arm;
      @(posedge clk) disable iff (sys_rst)
      sleep_wr && r_q.st == swc_pkg::ST_RUN && !(wake_req && gie) && !rst_any |=> r_q.st == swc_pkg::ST_ARMED;
   endproperty
   a_sleep_arm: assert property (p_sleep_arm) else $error("sleep write did not arm"); // [R1]

   property p_power_off;
      @(posedge clk) disable iff (sys_rst)
      cpu_halt |-> !imo_en && !bandgap_en && !flash_en && lvm_en && ilo_en;
   endproperty
   a_power_off: assert property (p_power_off) else $error("power state wrong in sleep"); // [R2]

   property p_refuse;
      @(posedge clk) disable iff (sys_rst)
      sleep_wr && r_q.st == swc_pkg::ST_RUN && wake_req && gie |=> r_q.st == swc_pkg::ST_RUN && r_q.ev[2];
   endproperty
   a_refuse: assert property (p_refuse) else $error("sleep entered with enabled pending interrupt"); // [R10]

   property p_prefetch;
      @(posedge clk) disable iff (sys_rst)
      r_q.st == swc_pkg::ST_ARMED && !(instr_boundary && prefetch_done) |=> r_q.st != swc_pkg::ST_SLEEP;
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("slept before prefetch done"); // [R19]

   property p_mask_wake;
      @(posedge clk) disable iff (sys_rst)
      r_q.st == swc_pkg::ST_SLEEP && wake_req && !rst_any |=> s_woke ##1 s_back_run;
   endproperty
   a_mask_wake: assert property (p_mask_wake) else $error("masked request did not wake"); // [R12] [R15]

   property p_wake_pending;
      @(posedge clk) disable iff (sys_rst)
      r_q.st == swc_pkg::ST_WAKE && !gie |-> !cpu_int_req ##1 (wake_req || $past(clr_mask != 5'h00));
   endproperty
   a_wake_pending: assert property (p_wake_pending) else $error("wake request lost without clear"); // [R13]

   property p_reset_boot;
      @(posedge clk) disable iff (sys_rst)
      $fell(rst_any) |=> boot_restart && r_q.st == swc_pkg::ST_RUN;
   endproperty
   a_reset_boot: assert property (p_reset_boot) else $error("no boot restart after reset"); // [R8]

   property p_ei_shadow;
      @(posedge clk) disable iff (sys_rst)
      ei_exec |=> !cpu_int_req;
   endproperty
   a_ei_shadow: assert property (p_ei_shadow) else $error("interrupt taken after enable"); // [R17]

   property p_timer;
      @(posedge clk) disable iff (sys_rst)
      tmr_hit |=> r_q.pend[0] && r_q.tmr_cnt == 15'h0000;
   endproperty
   a_timer: assert property (p_timer) else $error("sleep timer tick not pending"); // [R18]

   property p_hiz;
      @(posedge clk) disable iff (sys_rst)
      wr && paddr == `SWC_OFF_DM0 ##0 (r_q.dm1 == 8'hFF && r_q.dm2 == 8'hFF) |=>
         port_analog_hiz == ~$past(pwdata[7:0]);
   endproperty
   a_hiz: assert property (p_hiz) else $error("analog hi-z decode wrong"); // [R6] [R7]

   property p_pend_set;
      @(posedge clk) disable iff (sys_rst)
      (|src_lvl) |=> (r_q.pend & $past(src_lvl)) == $past(src_lvl);
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("wake source lost to a clear"); // [R9]

   property p_reset_run;
      @(posedge clk) disable iff (sys_rst)
      rst_any |=> r_q.st == swc_pkg::ST_RUN && !resume_next;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("reset did not end sleep"); // [R8]

   property p_boot_pulse;
      @(posedge clk) disable iff (sys_rst)
      boot_restart |=> !boot_restart;
   endproperty
   a_boot_pulse: assert property (p_boot_pulse) else $error("boot restart longer than one cycle"); // [R8]

   property p_resume_awake;
      @(posedge clk) disable iff (sys_rst)
      resume_next |-> r_q.st == swc_pkg::ST_WAKE && !cpu_halt && imo_en;
   endproperty
   a_resume_awake: assert property (p_resume_awake) else $error("resume while still halted"); // [R15]

   property p_arm_enter;
      @(posedge clk) disable iff (sys_rst)
      r_q.st == swc_pkg::ST_ARMED && instr_boundary && prefetch_done && !rst_any |=>
         r_q.st == swc_pkg::ST_SLEEP && r_q.ev[`SWC_EV_SLEPT];
   endproperty
   a_arm_enter: assert property (p_arm_enter) else $error("prefetched boundary did not enter sleep"); // [R19]
endmodule

// >>> tb/sleep_wake_control_tb.sv
// self-checking bench for the sleep and wake controller
`include "swc_consts.svh"
module sleep_wake_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // slow oscillator rate shortened so a 1 hz period is only 512 ticks
   localparam int ILO = 512;
   logic clk, sys_rst, psel, penable, pwrite, ilo_clk, gie, ei_exec, ib, pf, pready, pslverr, er;
   logic cpu_halt, cpu_int_req, boot_restart, resume_next, imo_en, bandgap_en, flash_en, lvm_en, ilo_en, irq;
   logic [7:0] paddr, dml, dmm, dmh, ahiz, r0, r1, r2;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] rpin;
   logic [3:0] spin, obs;
   int bad_count, total_checks, n, t;
   int hz [4] = '{`SWC_RATE0_HZ, `SWC_RATE1_HZ, `SWC_RATE2_HZ, `SWC_RATE3_HZ};
   assign obs = {boot_restart, resume_next, cpu_halt, cpu_int_req};

   swc_top #(.ILO_HZ(ILO)) uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ilo_clk(ilo_clk),
      .ext_rst(rpin[0]), .wdt_rst(rpin[1]), .por_rst(rpin[2]), .lvd_irq(spin[0]), .gpio_irq(spin[1]),
      .acol_irq(spin[2]), .async_irq(spin[3]), .gie(gie), .ei_exec(ei_exec), .instr_boundary(ib),
      .prefetch_done(pf), .cpu_halt(cpu_halt), .cpu_int_req(cpu_int_req), .boot_restart(boot_restart),
      .resume_next(resume_next), .imo_en(imo_en), .bandgap_en(bandgap_en), .flash_en(flash_en),
      .lvm_en(lvm_en), .ilo_en(ilo_en), .port_dm_low(dml), .port_dm_mid(dmm), .port_dm_high(dmh),
      .port_analog_hiz(ahiz), .irq(irq));

   // free-running system clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // counts, verdict and the end of the run
   task end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; read data and error are taken at the edge where pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      chk("pready", 1, pready);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // bounded wait for one observed output, sampled at rising edges
   task wait_hi(input int b, input string nm);
      n = 0;
      while (obs[b] !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      chk(nm, 1, obs[b]);
   endtask

   // one slow oscillator period, long enough for the two-flop synchroniser
   task tick();
      @(posedge clk);
      ilo_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ilo_clk <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // request sleep, raise the boundary, then hold off the prefetch for three cycles
   task sleep_in();
      apb(1, `SWC_OFF_SCR, 32'h0000_0008);
      @(posedge clk);
      ib <= 1'b1;
      repeat (3) @(posedge clk);
      chk("halt before prefetch", 0, cpu_halt);
      pf <= 1'b1;
      wait_hi(1, "cpu_halt");
      ib <= 1'b0;
      pf <= 1'b0;
      chk("power off", 0, {imo_en, bandgap_en, flash_en});
      chk("keep alive", 3, {lvm_en, ilo_en});
      apb(0, `SWC_OFF_SCR, 0);
      chk("sleep bit", 1, rd[`SWC_SCR_SLEEP]);
   endtask

   // watchdog: 1 ms is 50000 cycles, well above what the whole sequence needs
   initial
   begin
      #1ms;
      bad_count++;
      end_sim();
   end

   initial
   begin
      {sys_rst, psel, penable, pwrite, ilo_clk, gie, ei_exec, ib, pf} = 9'h100;
      paddr = 8'h00;
      pwdata = 32'h0;
      rpin = 3'h0;
      spin = 4'h0;
      void'($urandom(37));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("reset power", 5'h1F, {imo_en, bandgap_en, flash_en, lvm_en, ilo_en});
      chk("reset drive", {`SWC_DM0_RST, `SWC_DM1_RST, `SWC_DM2_RST}, {dml, dmm, dmh});
      apb(1, 8'h40, 32'h0000_00FF);
      chk("unmapped write err", 1, er);
      apb(0, 8'h40, 0);
      chk("unmapped read err", 1, er);
      chk("unmapped read", 32'h0000_0000, rd);
      // drive modes: first an analog high impedance corner, then random patterns
      for (int i = 0; i < 6; i++)
      begin
         r0 = (i == 0) ? 8'h00 : 8'($urandom);
         r1 = (i == 0) ? 8'hFF : 8'($urandom);
         r2 = (i == 0) ? 8'hFF : 8'($urandom);
         apb(1, `SWC_OFF_DM0, {24'h0, r0});
         apb(1, `SWC_OFF_DM1, {24'h0, r1});
         apb(1, `SWC_OFF_DM2, {24'h0, r2});
         #1;
         chk("drive bits", {r0, r1, r2}, {dml, dmm, dmh});
         chk("analog hiz", r2 & r1 & ~r0, ahiz);
         apb(0, `SWC_OFF_DM1, 0);
         chk("drive mid read", {24'h0, r1}, rd);
      end
      // sleep timer rates: count ticks to the first pending timer bit
      for (int k = 0; k < 4; k++)
      begin
         apb(1, `SWC_OFF_TMR, k);
         apb(1, `SWC_OFF_ICLR, 32'h1);
         for (t = 1; t < 600; t++)
         begin
            tick();
            apb(0, `SWC_OFF_ICLR, 0);
            if (rd[0] === 1'b1)
               break;
         end
         chk("timer ticks", ILO / hz[k], t);
      end
      // every wake source, with interrupts globally off
      apb(1, `SWC_OFF_EVMSK, 32'h7);
      for (int s = 0; s < `SWC_NSRC; s++)
      begin
         apb(1, `SWC_OFF_IMSK, 1 << s);
         apb(1, `SWC_OFF_ICLR, 32'h1F);
         apb(1, `SWC_OFF_EVST, 32'h7);
         sleep_in();
         chk("irq slept", 1, irq);
         // one slow clock rise only, so the short resume pulse is not missed
         if (s == 0)
            ilo_clk <= 1'b1;
         else
            spin[s - 1] <= 1'b1;
         wait_hi(2, "resume_next");
         chk("awake", 2'b01, {cpu_halt, imo_en});
         chk("no service", 0, cpu_int_req);
         spin <= 4'h0;
         ilo_clk <= 1'b0;
         repeat (4) @(posedge clk);
         apb(0, `SWC_OFF_ICLR, 0);
         chk("still pending", 1, rd[s]);
         apb(0, `SWC_OFF_EVST, 0);
         chk("events", 3, rd[1:0]);
         apb(1, `SWC_OFF_EVST, 32'h3);
         #1;
         chk("irq cleared", 0, irq);
         apb(1, `SWC_OFF_ICLR, 1 << s);
         apb(0, `SWC_OFF_ICLR, 0);
         chk("pending cleared", 0, rd[s]);
      end
      // masked-out sources do not wake; each reset cause does and restarts boot
      for (int i = 0; i < 3; i++)
      begin
         apb(1, `SWC_OFF_IMSK, 0);
         sleep_in();
         spin <= 4'hF;
         repeat (10) @(posedge clk);
         chk("masked stays asleep", 1, cpu_halt);
         spin <= 4'h0;
         rpin[i] <= 1'b1;
         repeat (3) @(posedge clk);
         rpin[i] <= 1'b0;
         wait_hi(3, "boot_restart");
         chk("reset wakes", 0, cpu_halt);
      end
      // pending enabled interrupt refuses sleep; no interrupt just after enable
      apb(1, `SWC_OFF_ICLR, 32'h1F);
      apb(1, `SWC_OFF_EVST, 32'h7);
      apb(1, `SWC_OFF_EVMSK, 32'h0);
      apb(1, `SWC_OFF_IMSK, 32'h4);
      gie <= 1'b1;
      spin[1] <= 1'b1;
      repeat (6) @(posedge clk);
      chk("int req", 1, cpu_int_req);
      ei_exec <= 1'b1;
      #1 chk("req at enable", 0, cpu_int_req);
      @(posedge clk);
      ei_exec <= 1'b0;
      #1 chk("req after enable", 0, cpu_int_req);
      @(posedge clk);
      #1 chk("req later", 1, cpu_int_req);
      apb(1, `SWC_OFF_SCR, 32'h0000_0008);
      ib <= 1'b1;
      pf <= 1'b1;
      repeat (4) @(posedge clk);
      chk("refused halt", 0, cpu_halt);
      ib <= 1'b0;
      pf <= 1'b0;
      apb(0, `SWC_OFF_SCR, 0);
      chk("refused bit", 0, rd[`SWC_SCR_SLEEP]);
      chk("irq masked", 0, irq);
      apb(0, `SWC_OFF_EVST, 0);
      chk("refused event", 1, rd[`SWC_EV_REFUSED]);
      apb(1, `SWC_OFF_EVMSK, 32'h4);
      #1;
      chk("irq unmasked", 1, irq);
      apb(1, `SWC_OFF_EVST, 32'h4);
      #1;
      chk("irq w1c", 0, irq);
      spin <= 4'h0;
      gie <= 1'b0;
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule
